// File: hdl/stxf_pkg.sv
// stxf_pkg: register map, field positions and timing constants of the transmit buffer block
// assumes a single 50 MHz system clock and a plain strobe register port
package stxf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS_DEF = 11;
  localparam int BAUD_DIV_DEF = 16;
  // register offsets
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CSA = 4'h1;
  localparam logic [3:0] OFS_CSB = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  // serial_ctrl_status_a fields
  localparam int CSA_TXC = 6;
  localparam int CSA_EMPTY = 5;
  // control register b fields
  localparam int CSB_EMPTY_IE = 5;
  localparam int CSB_TXC_IE = 6;
  localparam int CSB_NINTH = 0;
  localparam int CSB_NINE_EN = 2;
  localparam int CSB_GIE = 7;
  // sticky status / mask fields
  localparam int IRQ_EMPTY = 0;
  localparam int IRQ_TXC = 1;
  localparam logic [7:0] RST_CSB = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// File: hdl/stxf_shifter.sv
// stxf_shifter: serial shift stage that consumes one word from the holding buffer
// assumes a load pulse only while idle; frame = start, 8 or 9 data bits, stop
`timescale 1ns/1ns
`default_nettype none
module stxf_shifter #(
  parameter int BAUD_DIV = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // load side
  input wire logic i_load,
  input wire logic [7:0] i_data,
  input wire logic i_ninth,
  input wire logic i_nine_en,
  // status and line
  output logic o_busy,
  output logic o_done,
  output logic o_txd
);
  logic [10:0] sh_ff, nxt_sh;
  logic [3:0] left_ff, nxt_left;
  logic [15:0] div_ff, nxt_div;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic txd_ff, nxt_txd;

  always_comb
  begin
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_div = div_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_txd = txd_ff;
    if (i_load && !busy_ff)
    begin
      // ninth bit frozen with the word at load time
      nxt_sh = {1'b1, i_ninth, i_data, 1'b0};
      nxt_left = i_nine_en ? 4'(stxf_pkg::FRAME_BITS_DEF) : 4'(stxf_pkg::FRAME_BITS_DEF - 1);
      nxt_div = 16'h0000;
      nxt_busy = 1'b1;
      nxt_txd = 1'b1;
    end
    else if (busy_ff)
    begin
      if (div_ff == 16'h0000)
      begin
        nxt_txd = sh_ff[0];
        nxt_sh = {1'b1, sh_ff[10:1]};
        if (!i_nine_en && left_ff == 4'h2)
          nxt_sh = {1'b1, 1'b1, sh_ff[10:2]};
        nxt_left = left_ff - 4'h1;
        nxt_div = 16'(BAUD_DIV - 1);
        if (left_ff == 4'h0)
        begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_txd = 1'b1;
        end
      end
      else
        nxt_div = div_ff - 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      sh_ff <= 11'h7FF;
      left_ff <= 4'h0;
      div_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      txd_ff <= 1'b1;
    end
    else
    begin
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      div_ff <= nxt_div;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      txd_ff <= nxt_txd;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_txd = txd_ff;
endmodule
`default_nettype wire

// File: hdl/stxf_top.sv
// stxf_top: transmit holding buffer, buffer-empty and transmit-complete flags, interrupts
// assumes software on a plain strobe port; read data one cycle after the read strobe
// Functional notes
// - The buffer-empty flag is high whenever the holding buffer holds no word.
// - The buffer-empty flag stays low while a word waits in the holding buffer.
// - With its enable and global enable set, the empty interrupt requests while the flag is high.
// - A write to the data register clears the buffer-empty flag.
// - Nine-bit frames take the ninth bit from a control bit that software sets first.
// - The transmitter exposes buffer-empty and complete flags, each with its own request.
// - Transmit-complete sets once the frame has left and the holding buffer is empty.
// - Transmit-complete clears on interrupt service or by writing a one to its bit.
// - With its enable and global enable set, a complete interrupt requests on the flag.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module stxf_top #(
  parameter int BAUD_DIV = stxf_pkg::BAUD_DIV_DEF
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // interrupt service acknowledge for transmit complete
  input wire logic i_txc_irq_ack,
  // serial line and interrupts
  output logic o_txd,
  output logic o_empty_irq_req,
  output logic o_txc_irq_req,
  output logic o_irq
);
  logic [7:0] hold_ff, nxt_hold;
  logic full_ff, nxt_full;
  logic txc_ff, nxt_txc;
  logic [7:0] csb_ff, nxt_csb;
  logic [1:0] stat_ff, nxt_stat;
  logic [1:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic sh_busy, sh_done, load;
  logic wr_data, wr_csa, wr_csb, wr_stat, wr_mask;
  logic buffer_empty;

  assign wr_data = i_wr && (i_addr == stxf_pkg::OFS_DATA);
  assign wr_csa = i_wr && (i_addr == stxf_pkg::OFS_CSA);
  assign wr_csb = i_wr && (i_addr == stxf_pkg::OFS_CSB);
  assign wr_stat = i_wr && (i_addr == stxf_pkg::OFS_IRQ_STAT);
  assign wr_mask = i_wr && (i_addr == stxf_pkg::OFS_IRQ_MASK);
  assign buffer_empty = !full_ff;
  assign load = full_ff && !sh_busy;

  stxf_shifter #(
    .BAUD_DIV(BAUD_DIV)
  ) u_shift (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_load(load),
    .i_data(hold_ff),
    .i_ninth(csb_ff[stxf_pkg::CSB_NINTH]),
    .i_nine_en(csb_ff[stxf_pkg::CSB_NINE_EN]),
    .o_busy(sh_busy),
    .o_done(sh_done),
    .o_txd(o_txd)
  );

  // holding buffer and flags
  always_comb
  begin
    nxt_hold = hold_ff;
    nxt_full = full_ff;
    nxt_txc = txc_ff;
    if (load)
      nxt_full = 1'b0;
    // a write while the buffer is full overwrites the waiting word
    if (wr_data)
    begin
      nxt_hold = i_wdata;
      nxt_full = 1'b1;
    end
    // clears first so a completing frame in the same cycle still sets the flag
    if (i_txc_irq_ack)
      nxt_txc = 1'b0;
    if (wr_csa && i_wdata[stxf_pkg::CSA_TXC])
      nxt_txc = 1'b0;
    if (sh_done && !full_ff && !wr_data)
      nxt_txc = 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      hold_ff <= stxf_pkg::ZERO8;
      full_ff <= 1'b0;
      txc_ff <= 1'b0;
    end
    else
    begin
      hold_ff <= nxt_hold;
      full_ff <= nxt_full;
      txc_ff <= nxt_txc;
    end
  end

  // control register, sticky status and mask
  always_comb
  begin
    nxt_csb = csb_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    if (wr_csb)
      nxt_csb = i_wdata;
    if (wr_mask)
      nxt_mask = i_wdata[1:0];
    if (wr_stat)
      nxt_stat = stat_ff & ~i_wdata[1:0];
    // set wins over a write-one clear
    if (load)
      nxt_stat[stxf_pkg::IRQ_EMPTY] = 1'b1;
    if (nxt_txc && !txc_ff)
      nxt_stat[stxf_pkg::IRQ_TXC] = 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      csb_ff <= stxf_pkg::RST_CSB;
      mask_ff <= stxf_pkg::RST_MASK[1:0];
      stat_ff <= 2'h0;
    end
    else
    begin
      csb_ff <= nxt_csb;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
    end
  end

  // read port: data one cycle after the strobe, zero otherwise and for unmapped addresses
  always_comb
  begin
    nxt_rdata = stxf_pkg::ZERO8;
    if (i_rd)
    begin
      case (i_addr)
        stxf_pkg::OFS_DATA: nxt_rdata = hold_ff;
        stxf_pkg::OFS_CSA:
        begin
          nxt_rdata[stxf_pkg::CSA_TXC] = txc_ff;
          nxt_rdata[stxf_pkg::CSA_EMPTY] = buffer_empty;
        end
        stxf_pkg::OFS_CSB: nxt_rdata = csb_ff;
        stxf_pkg::OFS_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
        stxf_pkg::OFS_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
        default: nxt_rdata = stxf_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      rdata_ff <= stxf_pkg::ZERO8;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;
  // level request while empty; software must refill or drop the enable
  assign o_empty_irq_req = buffer_empty && csb_ff[stxf_pkg::CSB_EMPTY_IE]
                           && csb_ff[stxf_pkg::CSB_GIE];
  assign o_txc_irq_req = txc_ff && csb_ff[stxf_pkg::CSB_TXC_IE]
                         && csb_ff[stxf_pkg::CSB_GIE];
  assign o_irq = |(stat_ff & mask_ff);
endmodule
`default_nettype wire

// File: bench/stxf_top_sva.sv
// stxf_top_sva: port-level checks of the transmit flag block
// assumes one clock with synchronous reset, bound into every stxf_top
`timescale 1ns/1ns
`default_nettype none
module stxf_top_sva #(
  parameter int BAUD_DIV = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_txc_irq_ack,
  input wire logic o_txd,
  input wire logic o_empty_irq_req,
  input wire logic o_txc_irq_req,
  input wire logic o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic wr_dat;
  assign wr_dat = i_wr && i_addr == stxf_pkg::OFS_DATA;
  // refill may wait a whole frame behind a busy shifter
  sequence s_refill;
    !o_empty_irq_req ##[1:1000] o_empty_irq_req;
  endsequence
  property p_clr; wr_dat |=> !o_empty_irq_req; endproperty
  a_clr: assert property (p_clr) else $error("empty request after data write");
  property p_load; wr_dat && o_empty_irq_req |=> s_refill; endproperty
  a_load: assert property (p_load) else $error("buffer never moved");
  property p_hold; o_empty_irq_req && !i_wr |=> o_empty_irq_req; endproperty
  a_hold: assert property (p_hold) else $error("empty request dropped");
  property p_keep; o_txc_irq_req && !i_wr && !i_txc_irq_ack |=> o_txc_irq_req; endproperty
  a_keep: assert property (p_keep) else $error("complete request dropped");
  property p_ack; i_txc_irq_ack |=> !o_txc_irq_req; endproperty
  a_ack: assert property (p_ack) else $error("complete kept after service");
  property p_rise; $rose(o_txc_irq_req) && !$past(i_wr) |-> $past(o_txd) && o_txd; endproperty
  a_rise: assert property (p_rise) else $error("complete set mid frame");
  property p_rd; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
  property p_start; $fell(o_txd) |-> !o_txd [*2]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule
bind stxf_top stxf_top_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_txc_irq_ack(i_txc_irq_ack), .o_txd(o_txd), .o_empty_irq_req(o_empty_irq_req),
  .o_txc_irq_req(o_txc_irq_req), .o_irq(o_irq));
`default_nettype wire

// File: bench/stxf_line_rx.sv
// stxf_line_rx: behavioural listener on the serial line, counts good frames
// assumes idle-high line, lsb first, BAUD_DIV clocks a bit
`timescale 1ns/1ns
`default_nettype none
module stxf_line_rx #(
  parameter int BAUD_DIV = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_txd,
  input wire logic i_nine,
  output logic [8:0] o_word,
  output var int o_frames
);
  initial o_frames = 0;
  initial o_word = 9'h000;
  always
  begin
    @(negedge i_txd);
    // sample mid bit so a late edge still reads right
    repeat (BAUD_DIV / 2) @(posedge i_sys_clk);
    for (int i = 0; i < (i_nine ? 9 : 8); i++)
    begin
      repeat (BAUD_DIV) @(posedge i_sys_clk);
      o_word[i] = i_txd;
    end
    if (!i_nine) o_word[8] = 1'b0;
    repeat (BAUD_DIV) @(posedge i_sys_clk);
    if (i_txd) o_frames++;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// testbench: directed checks of buffer-empty, complete and ninth-bit behaviour
// assumes a short bit time and the line listener on the serial output
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_txc_irq_ack = 1'b0;
  logic nine = 1'b0;
  logic ereq;
  logic [7:0] rdata;
  logic txd, emp_req, txc_req, irq;
  logic [8:0] word;
  int frames;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  stxf_top #(.BAUD_DIV(4)) u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_txc_irq_ack(i_txc_irq_ack),
    .o_txd(txd), .o_empty_irq_req(emp_req), .o_txc_irq_req(txc_req), .o_irq(irq));
  stxf_line_rx #(.BAUD_DIV(4)) u_rx (.i_sys_clk(i_sys_clk), .i_txd(txd), .i_nine(nine),
    .o_word(word), .o_frames(frames));
  task automatic check(input string n, input logic [8:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // one strobe, then an idle cycle so no signal is driven twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
    q = rdata;
    ereq = emp_req;
    @(posedge i_sys_clk);
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 400 && frames < n; i++) @(posedge i_sys_clk);
    check("frames", 9'(frames), 9'(n));
  endtask
  task automatic t_reset();
    logic [7:0] q;
    bus(1'b0, stxf_pkg::OFS_CSA, 8'h00, q);
    check("csa", q, 8'h20);
    bus(1'b0, 4'hF, 8'h00, q);
    check("unmapped", q, 8'h00);
    check("txd", txd, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_frame();
    logic [7:0] q;
    bus(1'b1, stxf_pkg::OFS_CSB, 8'hE0, q);
    check("emp_req", emp_req, 1'b1);
    bus(1'b1, stxf_pkg::OFS_DATA, 8'hA5, q);
    check("emp_c1", ereq, 1'b0);
    bus(1'b0, stxf_pkg::OFS_CSA, 8'h00, q);
    check("csa_moved", q, 8'h20);
    bus(1'b1, stxf_pkg::OFS_DATA, 8'h3C, q);
    bus(1'b0, stxf_pkg::OFS_CSA, 8'h00, q);
    check("csa_full", q, 8'h00);
    wait_frames(2);
    check("word", word, 9'h03C);
    for (int i = 0; i < 50 && !txc_req; i++) @(posedge i_sys_clk);
    check("txc_req", txc_req, 1'b1);
    bus(1'b1, stxf_pkg::OFS_IRQ_MASK, 8'h03, q);
    check("irq", irq, 1'b1);
    bus(1'b0, stxf_pkg::OFS_IRQ_STAT, 8'h00, q);
    check("stat", q, 8'h03);
    bus(1'b0, stxf_pkg::OFS_IRQ_MASK, 8'h00, q);
    check("mask", q, 8'h03);
    i_txc_irq_ack <= 1'b1;
    @(posedge i_sys_clk);
    i_txc_irq_ack <= 1'b0;
    @(posedge i_sys_clk);
    check("txc_ack", txc_req, 1'b0);
    bus(1'b1, stxf_pkg::OFS_IRQ_STAT, 8'h03, q);
    check("irq_clr", irq, 1'b0);
    bus(1'b1, stxf_pkg::OFS_CSB, 8'h80, q);
    check("emp_off", emp_req, 1'b0);
    bus(1'b0, stxf_pkg::OFS_CSB, 8'h00, q);
    check("csb", q, 8'h80);
    $display("t_frame done");
  endtask
  task automatic t_ninth();
    logic [7:0] q;
    nine = 1'b1;
    for (int n = 0; n < 2; n++)
    begin
      bus(1'b1, stxf_pkg::OFS_CSB, {7'h02, n[0]}, q);
      bus(1'b1, stxf_pkg::OFS_DATA, 8'h5A, q);
      bus(1'b1, stxf_pkg::OFS_CSB, {7'h02, !n[0]}, q);
      wait_frames(3 + n);
      check("ninth", word, {n[0], 8'h5A});
    end
    for (int i = 0; i < 20 && q !== 8'h60; i++) bus(1'b0, stxf_pkg::OFS_CSA, 8'h00, q);
    check("csa_txc", q, 8'h60);
    bus(1'b1, stxf_pkg::OFS_CSA, 8'h00, q);
    bus(1'b1, stxf_pkg::OFS_CSA, 8'h40, q);
    bus(1'b0, stxf_pkg::OFS_CSA, 8'h00, q);
    check("csa_w1c", q, 8'h20);
    $display("t_ninth done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_frame();
    t_ninth();
    print_verdict();
  end
endmodule
`default_nettype wire
